// ### core/kpr_code_table.sv
/*
 * kpr_code_table: twelve key-down and twelve key-up codes, one read port with
 * registered data and one write port.
 * assumes indices below twenty-four; reset loads the default codes.
 */
`timescale 1ns/1ps
module kpr_code_table (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic wr_en_i,
   input wire logic [4:0] wr_idx_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [4:0] rd_idx_i,
   output logic [7:0] rd_data_o
);
   import kpr_pkg::*;

   kpr_table_st_s s;
   kpr_table_st_s next_s;

   always_comb
   begin
      next_s = s;
      if (wr_en_i)
      begin
         next_s.mem[wr_idx_i] = wr_data_i;
      end
      next_s.rd_data = s.mem[rd_idx_i];
      if (!rst_b_i)
      begin
         for (int i = 0; i < NUM_KEYS; i++)
         begin
            next_s.mem[i] = DOWN_BASE + 8'(i);
            next_s.mem[i + NUM_KEYS] = UP_BASE + 8'(i);
         end
         next_s.rd_data = 8'h00;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      s <= next_s;
   end

   assign rd_data_o = s.rd_data;

endmodule

// ### core/kpr_key_fifo.sv
/*
 * kpr_key_fifo: ten-entry buffer of key codes with registered read data.
 * assumes one push, one pop and one clear request per cycle at most.
 */
`timescale 1ns/1ps
module kpr_key_fifo (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic clr_i,
   input wire logic wr_en_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_en_i,
   output logic [7:0] rd_data_o,
   output logic [3:0] count_o,
   output logic empty_o
);
   import kpr_pkg::*;

   kpr_fifo_st_s s;
   kpr_fifo_st_s next_s;
   logic [3:0] base_cnt;
   logic push;
   logic pop;

   always_comb
   begin
      next_s = s;
      base_cnt = clr_i ? 4'h0 : s.cnt;
      // a full buffer drops new events until read or cleared
      push = wr_en_i && (base_cnt != FIFO_FULL_CNT);
      pop = rd_en_i && !clr_i && (base_cnt != 4'h0);
      if (clr_i)
      begin
         next_s.wp = 4'h0;
         next_s.rp = 4'h0;
      end
      if (pop)
      begin
         next_s.rd_data = s.mem[s.rp];
         next_s.rp = (s.rp == FIFO_LAST) ? 4'h0 : s.rp + 4'h1;
      end
      if (push)
      begin
         next_s.mem[next_s.wp] = wr_data_i;
         next_s.wp = (next_s.wp == FIFO_LAST) ? 4'h0 : next_s.wp + 4'h1;
      end
      next_s.cnt = base_cnt + 4'(push) - 4'(pop);
      if (!rst_b_i)
      begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      s <= next_s;
   end

   assign rd_data_o = s.rd_data;
   assign count_o = s.cnt;
   assign empty_o = (s.cnt == 4'h0);

   chk_full_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s.cnt == FIFO_FULL_CNT && wr_en_i && !rd_en_i && !clr_i)
      |=> (s.cnt == FIFO_FULL_CNT && s.wp == $past(s.wp)))
      else $error("full key buffer accepted an event");

endmodule

// ### core/kpr_keypad_reporter.sv
/*
 * kpr_keypad_reporter: debounces twelve keys, generates key-down, key-up and
 * repeat events, and interprets keypad command bytes written over AXI4-Lite.
 * assumes key inputs synchronous to clk_sys_i, one pressed key at a time
 * (lowest index wins), and a host that reads the tx register for answers.
 */
`timescale 1ns/1ps
module kpr_keypad_reporter #(
   parameter int DEB_UNIT_CYC_P = kpr_pkg::DEB_UNIT_CYC,
   parameter int TYPE_DELAY_CYC_P = kpr_pkg::TYPE_DELAY_CYC,
   parameter int TYPE_PERIOD_CYC_P = kpr_pkg::TYPE_PERIOD_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire kpr_pkg::kpr_axi_req_s axi_req_i,
   output kpr_pkg::kpr_axi_rsp_s axi_rsp_o,
   input wire logic [kpr_pkg::NUM_KEYS-1:0] key_i,
   output logic general_output_pin_mode_o
);
   import kpr_pkg::*;

   kpr_main_st_s s;
   kpr_main_st_s next_s;
   logic [3:0] raw_key;
   logic wr_go;
   logic cmd_go;
   logic [7:0] cmd_byte;
   logic poll_go;
   logic deb_done;
   logic [24:0] rep_lim;
   logic ev_go;
   logic [4:0] ev_idx;
   logic tbl_wr_en;
   logic [4:0] tbl_wr_idx;
   logic [7:0] tbl_rd_data;
   logic fifo_clr;
   logic fifo_rd;
   logic [7:0] fifo_rd_data;
   logic [3:0] fifo_cnt;
   logic fifo_empty;

   kpr_code_table u_table (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .wr_en_i(tbl_wr_en),
      .wr_idx_i(tbl_wr_idx),
      .wr_data_i(cmd_byte),
      .rd_idx_i(ev_idx),
      .rd_data_o(tbl_rd_data)
   );

   kpr_key_fifo u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .clr_i(fifo_clr),
      .wr_en_i(s.lk_pend),
      .wr_data_i(tbl_rd_data),
      .rd_en_i(fifo_rd),
      .rd_data_o(fifo_rd_data),
      .count_o(fifo_cnt),
      .empty_o(fifo_empty)
   );

   always_comb
   begin
      next_s = s;
      cmd_go = 1'b0;
      cmd_byte = s.wbyte;
      poll_go = 1'b0;
      ev_go = 1'b0;
      ev_idx = 5'h00;
      tbl_wr_en = 1'b0;
      tbl_wr_idx = s.arg_cnt;
      fifo_clr = 1'b0;
      fifo_rd = 1'b0;
      rep_lim = 25'h000_0000;
      raw_key = KEY_NONE;
      // keypad is blind while the header serves as general output
      for (int k = NUM_KEYS - 1; k >= 0; k--)
      begin
         if (key_i[k] && !s.pin_mode)
         begin
            raw_key = 4'(k);
         end
      end

      // ****************************************
      // axi4-lite write channel
      // ****************************************
      if (s.rsp.awready && axi_req_i.awvalid)
      begin
         next_s.rsp.awready = 1'b0;
         next_s.aw_got = 1'b1;
         next_s.awaddr = axi_req_i.awaddr;
      end
      if (s.rsp.wready && axi_req_i.wvalid)
      begin
         next_s.rsp.wready = 1'b0;
         next_s.w_got = 1'b1;
         next_s.wbyte = axi_req_i.wdata[7:0];
         next_s.wlane = axi_req_i.wstrb[0];
      end
      wr_go = s.aw_got && s.w_got && !s.rsp.bvalid;
      if (wr_go)
      begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.rsp.bvalid = 1'b1;
         next_s.rsp.bresp = (s.awaddr inside {ADDR_CMD, ADDR_TX, ADDR_STAT, ADDR_CFG}) ?
            RESP_OKAY : RESP_SLVERR;
         cmd_go = (s.awaddr == ADDR_CMD) && s.wlane;
      end
      if (s.rsp.bvalid && axi_req_i.bready)
      begin
         next_s.rsp.bvalid = 1'b0;
         next_s.rsp.awready = 1'b1;
         next_s.rsp.wready = 1'b1;
      end

      // ****************************************
      // axi4-lite read channel
      // ****************************************
      if (s.rsp.arready && axi_req_i.arvalid)
      begin
         next_s.rsp.arready = 1'b0;
         next_s.rsp.rvalid = 1'b1;
         next_s.rsp.rresp = RESP_OKAY;
         next_s.rsp.rdata = 32'h0000_0000;
         case (axi_req_i.araddr)
            ADDR_CMD:
            begin
               next_s.rsp.rdata = 32'h0000_0000;
            end
            ADDR_TX:
            begin
               // reading consumes the byte; a load in this same cycle wins below
               next_s.rsp.rdata[TX_VALID_BIT:0] = {s.tx_valid, s.tx_byte};
               next_s.tx_valid = 1'b0;
            end
            ADDR_STAT:
            begin
               next_s.rsp.rdata[STAT_PUSH] = s.push_en;
               next_s.rsp.rdata[STAT_REP] = s.rep_en;
               next_s.rsp.rdata[STAT_HOLD] = s.hold_mode;
               next_s.rsp.rdata[STAT_PIN] = s.pin_mode;
               next_s.rsp.rdata[STAT_CNT_LSB +: 4] = fifo_cnt;
               next_s.rsp.rdata[STAT_KEY_LSB +: 4] = s.cur_key;
            end
            ADDR_CFG:
            begin
               next_s.rsp.rdata[7:0] = s.deb;
            end
            default:
            begin
               next_s.rsp.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (s.rsp.rvalid && axi_req_i.rready)
      begin
         next_s.rsp.rvalid = 1'b0;
         next_s.rsp.arready = 1'b1;
      end

      // ****************************************
      // command interpreter
      // ****************************************
      if (cmd_go)
      begin
         unique case (s.pst)
            PS_IDLE:
            begin
               // display text is someone else's business
               if (cmd_byte == CMD_PREFIX)
               begin
                  next_s.pst = PS_PREFIX;
               end
            end
            PS_PREFIX:
            begin
               next_s.pst = PS_IDLE;
               case (cmd_byte)
                  CMD_PUSH_OFF: next_s.push_en = 1'b0;
                  CMD_POLL: poll_go = 1'b1;
                  CMD_CLEAR: fifo_clr = 1'b1;
                  CMD_DEBOUNCE: next_s.pst = PS_DEB;
                  CMD_REP_MODE: next_s.pst = PS_REP;
                  CMD_REP_OFF: next_s.rep_en = 1'b0;
                  CMD_PIN_MODE: next_s.pst = PS_PIN;
                  CMD_ASSIGN:
                  begin
                     next_s.pst = PS_CODES;
                     next_s.arg_cnt = 5'h00;
                  end
                  default: next_s.pst = PS_IDLE;
               endcase
            end
            PS_DEB:
            begin
               next_s.deb = cmd_byte;
               next_s.pst = PS_IDLE;
            end
            PS_REP:
            begin
               next_s.hold_mode = (cmd_byte == ARG_ONE);
               next_s.rep_en = 1'b1;
               next_s.pst = PS_IDLE;
            end
            PS_PIN:
            begin
               next_s.pin_mode = (cmd_byte == ARG_ONE);
               next_s.pst = PS_IDLE;
            end
            PS_CODES:
            begin
               // down codes land at 0..11, up codes at 12..23, row-major
               tbl_wr_en = (cmd_byte != KEY_SKIP);
               next_s.arg_cnt = s.arg_cnt + 5'h01;
               if (s.arg_cnt == CODES_LAST)
               begin
                  next_s.pst = PS_IDLE;
               end
            end
         endcase
      end

      // ****************************************
      // poll answers and push drain
      // ****************************************
      if (poll_go)
      begin
         if (fifo_empty)
         begin
            next_s.tx_byte = POLL_EMPTY;
            next_s.tx_valid = 1'b1;
         end
         else
         begin
            fifo_rd = 1'b1;
            next_s.poll_pend = 1'b1;
            next_s.poll_more = (fifo_cnt > 4'h1);
         end
      end
      else if (s.push_en && !s.tx_valid && !s.drain_pend && !s.poll_pend && !fifo_empty)
      begin
         fifo_rd = 1'b1;
         next_s.drain_pend = 1'b1;
      end
      if (s.poll_pend)
      begin
         next_s.tx_byte = {s.poll_more, fifo_rd_data[6:0]};
         next_s.tx_valid = 1'b1;
         next_s.poll_pend = 1'b0;
      end
      if (s.drain_pend)
      begin
         next_s.tx_byte = fifo_rd_data;
         next_s.tx_valid = 1'b1;
         next_s.drain_pend = 1'b0;
      end

      // ****************************************
      // debounce and repeat
      // ****************************************
      deb_done = (s.deb_ticks >= s.deb);
      if (raw_key != s.cand_key)
      begin
         next_s.cand_key = raw_key;
         next_s.pre_cnt = 18'h0_0000;
         next_s.deb_ticks = 8'h00;
      end
      else if (raw_key != s.cur_key)
      begin
         if (deb_done)
         begin
            // a change of key releases the old one first, then presses the new
            if (s.cur_key != KEY_NONE)
            begin
               next_s.cur_key = KEY_NONE;
               ev_go = s.rep_en && s.hold_mode;
               ev_idx = 5'(s.cur_key) + KEY_UP_OFS;
            end
            else
            begin
               next_s.cur_key = s.cand_key;
               ev_go = 1'b1;
               ev_idx = {1'b0, s.cand_key};
               next_s.rep_cnt = 25'h000_0000;
               next_s.rep_first = 1'b1;
            end
         end
         else if (s.pre_cnt == 18'(DEB_UNIT_CYC_P - 1))
         begin
            next_s.pre_cnt = 18'h0_0000;
            next_s.deb_ticks = s.deb_ticks + 8'h01;
         end
         else
         begin
            next_s.pre_cnt = s.pre_cnt + 18'h0_0001;
         end
      end
      else if (s.cur_key != KEY_NONE && s.rep_en && !s.hold_mode)
      begin
         rep_lim = s.rep_first ? 25'(TYPE_DELAY_CYC_P - 1) : 25'(TYPE_PERIOD_CYC_P - 1);
         if (s.rep_cnt == rep_lim)
         begin
            next_s.rep_cnt = 25'h000_0000;
            next_s.rep_first = 1'b0;
            ev_go = 1'b1;
            ev_idx = {1'b0, s.cur_key};
         end
         else
         begin
            next_s.rep_cnt = s.rep_cnt + 25'h000_0001;
         end
      end
      // code arrives from the table one cycle later and goes to the buffer
      next_s.lk_pend = ev_go;

      if (!rst_b_i)
      begin
         next_s = '0;
         next_s.rsp.awready = 1'b1;
         next_s.rsp.wready = 1'b1;
         next_s.rsp.arready = 1'b1;
         next_s.pst = PS_IDLE;
         next_s.push_en = 1'b1;
         next_s.rep_en = 1'b1;
         next_s.hold_mode = 1'b0;
         next_s.deb = DEB_RESET;
         next_s.cur_key = KEY_NONE;
         next_s.cand_key = KEY_NONE;
         tbl_wr_en = 1'b0;
         fifo_rd = 1'b0;
         fifo_clr = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      s <= next_s;
   end

   assign axi_rsp_o = s.rsp;
   assign general_output_pin_mode_o = s.pin_mode;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb_sys @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence seq_drain;
      s.drain_pend ##1 s.tx_valid;
   endsequence

   sequence seq_poll_more;
      s.poll_pend ##1 (s.tx_valid && s.tx_byte[7]);
   endsequence

   sequence seq_poll_last;
      s.poll_pend ##1 (s.tx_valid && !s.tx_byte[7]);
   endsequence

   chk_push_drain: assert property (
      (s.push_en && !s.tx_valid && !s.drain_pend && !s.poll_pend && !fifo_empty && !poll_go)
      |=> seq_drain)
      else $error("push mode did not forward a buffered key");

   chk_push_held: assert property ((!s.push_en ##1 !s.push_en) |-> !s.drain_pend)
      else $error("key forwarded while push mode off");

   chk_poll_last: assert property ((poll_go && fifo_cnt == 4'h1) |=> seq_poll_last)
      else $error("last polled key has wrong answer");

   chk_poll_more: assert property ((poll_go && fifo_cnt > 4'h1) |=> seq_poll_more)
      else $error("poll answer lacks more-keys flag");

   chk_poll_empty: assert property (
      (poll_go && fifo_empty) |=> (s.tx_valid && s.tx_byte == POLL_EMPTY))
      else $error("empty poll did not return zero");

   chk_buf_clear: assert property ((fifo_clr && !s.lk_pend) |=> fifo_empty)
      else $error("clear left keys in the buffer");

   chk_deb_wait: assert property (
      (s.cur_key != $past(s.cur_key) && s.cur_key != KEY_NONE)
      |-> ($past(s.deb_ticks) >= $past(s.deb)))
      else $error("key accepted before debounce time");

   chk_deb_default: assert property ($rose(rst_b_i) |-> (s.deb == DEB_RESET && s.push_en))
      else $error("wrong debounce or push default");

   chk_rep_mode: assert property (
      (cmd_go && s.pst == PS_REP) |=> (s.hold_mode == ($past(cmd_byte) == ARG_ONE)))
      else $error("repeat mode byte not applied");

   chk_rep_off: assert property (
      (cmd_go && s.pst == PS_PREFIX && cmd_byte == CMD_REP_OFF)
      |=> !s.rep_en ##1 !(ev_go && s.cur_key != KEY_NONE && s.cand_key == s.cur_key))
      else $error("repeat off not applied");

   chk_codes_end: assert property (
      (cmd_go && s.pst == PS_CODES && s.arg_cnt == CODES_LAST) |=> (s.pst == PS_IDLE))
      else $error("code assignment length wrong");

   chk_key_skip: assert property ((tbl_wr_en) |-> (cmd_byte != KEY_SKIP))
      else $error("skip code overwrote a key code");

   chk_pin_mode: assert property (
      (cmd_go && s.pst == PS_PIN) |=> (s.pin_mode == ($past(cmd_byte) == ARG_ONE)))
      else $error("pin mode byte not applied");

endmodule

// ### core/kpr_pkg.sv
/*
 * kpr_pkg: constants, command codes, register map and state carriers for the
 * keypad event reporter.
 * assumes a 20 MHz system clock and a 32-bit AXI4-Lite register master.
 */
package kpr_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int DEB_UNIT_US = 6554;
   localparam int DEB_UNIT_CYC = DEB_UNIT_US * 1000 / CLK_PERIOD_NS;
   localparam int TYPE_DELAY_MS = 1000;
   localparam int TYPE_DELAY_CYC = TYPE_DELAY_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TYPE_RATE_HZ = 5;
   localparam int TYPE_PERIOD_CYC = 1000000000 / (TYPE_RATE_HZ * CLK_PERIOD_NS);

   // ****************************************
   // sizes and key codes
   // ****************************************
   localparam int NUM_KEYS = 12;
   localparam int NUM_CODES = 24;
   localparam int FIFO_DEPTH = 10;
   localparam logic [3:0] FIFO_FULL_CNT = 4'ha;
   localparam logic [3:0] FIFO_LAST = 4'h9;
   localparam logic [4:0] CODES_LAST = 5'h17;
   localparam logic [4:0] KEY_UP_OFS = 5'h0c;
   localparam logic [3:0] KEY_NONE = 4'hf;
   localparam logic [7:0] DEB_RESET = 8'h08;
   localparam logic [7:0] DOWN_BASE = 8'h41;
   localparam logic [7:0] UP_BASE = 8'h61;
   localparam logic [7:0] KEY_SKIP = 8'hff;
   localparam logic [7:0] POLL_EMPTY = 8'h00;
   localparam logic [7:0] ARG_ONE = 8'h01;

   // ****************************************
   // command bytes
   // ****************************************
   localparam logic [7:0] CMD_PREFIX = 8'hfe;
   localparam logic [7:0] CMD_PUSH_OFF = 8'h4f;
   localparam logic [7:0] CMD_POLL = 8'h26;
   localparam logic [7:0] CMD_CLEAR = 8'h45;
   localparam logic [7:0] CMD_DEBOUNCE = 8'h55;
   localparam logic [7:0] CMD_REP_MODE = 8'h7e;
   localparam logic [7:0] CMD_REP_OFF = 8'h60;
   localparam logic [7:0] CMD_ASSIGN = 8'hd5;
   localparam logic [7:0] CMD_PIN_MODE = 8'h25;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_TX = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_CFG = 8'h0c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int TX_VALID_BIT = 8;
   localparam int STAT_PUSH = 0;
   localparam int STAT_REP = 1;
   localparam int STAT_HOLD = 2;
   localparam int STAT_PIN = 3;
   localparam int STAT_CNT_LSB = 4;
   localparam int STAT_KEY_LSB = 8;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {PS_IDLE, PS_PREFIX, PS_DEB, PS_REP, PS_PIN, PS_CODES} kpr_parse_e;

   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } kpr_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } kpr_axi_rsp_s;

   typedef struct packed {
      logic [FIFO_DEPTH-1:0][7:0] mem;
      logic [3:0] wp;
      logic [3:0] rp;
      logic [3:0] cnt;
      logic [7:0] rd_data;
   } kpr_fifo_st_s;

   typedef struct packed {
      logic [NUM_CODES-1:0][7:0] mem;
      logic [7:0] rd_data;
   } kpr_table_st_s;

   typedef struct packed {
      kpr_axi_rsp_s rsp;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [7:0] wbyte;
      logic wlane;
      kpr_parse_e pst;
      logic [4:0] arg_cnt;
      logic push_en;
      logic rep_en;
      logic hold_mode;
      logic pin_mode;
      logic [7:0] deb;
      logic [7:0] tx_byte;
      logic tx_valid;
      logic drain_pend;
      logic poll_pend;
      logic poll_more;
      logic [3:0] cur_key;
      logic [3:0] cand_key;
      logic [17:0] pre_cnt;
      logic [7:0] deb_ticks;
      logic [24:0] rep_cnt;
      logic rep_first;
      logic lk_pend;
   } kpr_main_st_s;

endpackage

// ### test/kpr_host_model.sv
/*
 * kpr_host_model: axi4-lite master standing in for the host controller.
 * assumes registered slave outputs on clk_sys_i.
 */
`timescale 1ns/1ps
module kpr_host_model (
   input wire logic clk_sys_i,
   input wire kpr_pkg::kpr_axi_rsp_s rsp_i,
   output kpr_pkg::kpr_axi_req_s req_o
);
   import kpr_pkg::*;
   // ****
   // bus cycles
   // ****
   logic h;
   logic g;
   logic b;
   initial req_o = '0;
   // handshakes judged at the falling edge, acted on at the next rising one
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      req_o.awaddr <= a;
      req_o.wdata <= {24'h00_0000, d};
      req_o.wstrb <= 4'hf;
      req_o.awvalid <= 1'b1;
      req_o.wvalid <= 1'b1;
      req_o.bready <= 1'b1;
      do
      begin
         @(negedge clk_sys_i);
         h = rsp_i.awready && req_o.awvalid;
         g = rsp_i.wready && req_o.wvalid;
         b = rsp_i.bvalid;
         @(posedge clk_sys_i);
         if (h) req_o.awvalid <= 1'b0;
         if (g) req_o.wvalid <= 1'b0;
      end
      while (!b);
      req_o.bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
      @(posedge clk_sys_i);
      req_o.araddr <= a;
      req_o.arvalid <= 1'b1;
      req_o.rready <= 1'b1;
      do
      begin
         @(negedge clk_sys_i);
         h = rsp_i.arready && req_o.arvalid;
         b = rsp_i.rvalid;
         d = rsp_i.rdata;
         e = rsp_i.rresp;
         @(posedge clk_sys_i);
         if (h) req_o.arvalid <= 1'b0;
      end
      while (!b);
      req_o.rready <= 1'b0;
   endtask
endmodule

// ### test/kpr_keypad_reporter_test.sv
/*
 * kpr_keypad_reporter_test: self-checking bench for the keypad reporter.
 * assumes kpr_host_model as bus master; shortened debounce and repeat counts.
 */
`timescale 1ns/1ps
module kpr_keypad_reporter_test;
   import kpr_pkg::*;
   // ****
   // setup
   // ****
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [NUM_KEYS-1:0] key = '0;
   logic pin;
   kpr_axi_req_s req;
   kpr_axi_rsp_s rsp;
   logic [31:0] d;
   logic [1:0] e;
   int n_fail = 0;
   int tests_run = 0;
   int row_key [3] = '{0, 5, 11};
   logic [7:0] row_exp [3] = '{8'hc1, 8'hc6, 8'h4c};
   always #25 clk_sys_i = ~clk_sys_i;
   kpr_keypad_reporter #(.DEB_UNIT_CYC_P(4), .TYPE_DELAY_CYC_P(40), .TYPE_PERIOD_CYC_P(8))
   kpr_keypad_reporter_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .axi_req_i(req),
      .axi_rsp_o(rsp), .key_i(key), .general_output_pin_mode_o(pin));
   kpr_host_model kpr_host_model_inst (.clk_sys_i(clk_sys_i), .rsp_i(rsp), .req_o(req));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task rdw(input logic [7:0] a);
      kpr_host_model_inst.rd(a, d, e);
   endtask
   task cmd(input logic [7:0] c);
      kpr_host_model_inst.wr(ADDR_CMD, CMD_PREFIX);
      kpr_host_model_inst.wr(ADDR_CMD, c);
   endtask
   task arg(input logic [7:0] c, input logic [7:0] x);
      cmd(c);
      kpr_host_model_inst.wr(ADDR_CMD, x);
   endtask
   // release held 20 cycles: enough for its own debounce at setting 2, not at the reset default of 8
   task press(input int k, input int n);
      @(posedge clk_sys_i);
      key <= 12'h001 << k;
      repeat (n) @(posedge clk_sys_i);
      key <= '0;
      repeat (20) @(posedge clk_sys_i);
   endtask
   task poll(input logic [7:0] x);
      cmd(CMD_POLL);
      repeat (4) @(posedge clk_sys_i);
      rdw(ADDR_TX);
      chk(d, {23'h00_0000, 1'b1, x});
   endtask
   task test_done;
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      n_fail++;
      test_done;
   end
   // ****
   // sequence
   // ****
   initial
   begin
      repeat (3) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      rdw(ADDR_STAT);
      chk(d, 32'h0000_0f03);
      rdw(ADDR_CFG);
      chk(d, 32'h0000_0008);
      rdw(8'h10);
      chk(32'(e), 32'(RESP_SLVERR));
      arg(CMD_DEBOUNCE, 8'h02);
      rdw(ADDR_CFG);
      chk(d, 32'h0000_0002);
      press(0, 20);
      rdw(ADDR_TX);
      chk(d, 32'h0000_0141);
      cmd(CMD_REP_OFF);
      cmd(CMD_PUSH_OFF);
      press(3, 3);
      for (int i = 0; i < 3; i++) press(row_key[i], 60);
      for (int i = 0; i < 3; i++) poll(row_exp[i]);
      poll(POLL_EMPTY);
      cmd(CMD_ASSIGN);
      for (int i = 0; i < 24; i++) arg_byte(i);
      press(0, 20);
      press(1, 20);
      poll(8'hb0);
      poll(8'h42);
      arg(CMD_REP_MODE, ARG_ONE);
      press(2, 20);
      poll(8'hc3);
      poll(8'h63);
      arg(CMD_REP_MODE, 8'h00);
      press(1, 62);
      poll(8'hc2);
      poll(8'hc2);
      poll(8'h42);
      cmd(CMD_REP_OFF);
      for (int i = 0; i < 11; i++) press(4, 14);
      rdw(ADDR_STAT);
      chk(32'(d[7:4]), 32'h0000_000a);
      cmd(CMD_CLEAR);
      poll(POLL_EMPTY);
      arg(CMD_PIN_MODE, ARG_ONE);
      chk(32'(pin), 32'h0000_0001);
      press(0, 20);
      rdw(ADDR_STAT);
      chk(32'(d[7:4]), 32'h0000_0000);
      // mid-run reset must bring back every default
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      rdw(ADDR_STAT);
      chk(d, 32'h0000_0f03);
      rdw(ADDR_CFG);
      chk(d, 32'h0000_0008);
      press(0, 50);
      rdw(ADDR_TX);
      chk(d, 32'h0000_0141);
      test_done;
   end
   // full table sent even though only the first down code changes
   task arg_byte(input int i);
      kpr_host_model_inst.wr(ADDR_CMD, (i == 0) ? 8'h30 : KEY_SKIP);
   endtask
endmodule
